// ### core/rtcw_core.sv
// Wakeup countdown timer and time update interrupt logic of a real-time clock.
// Assumes a bus engine delivers register writes and sampled SCL; ticks are one-cycle strobes.
// How it works
// R1: Countdown starts at SCL rise after enabling
// R2: Preset loaded on first source tick
// R3: Decrement per tick; 1 to 0 reloads
// R4: Interval is preset times source period
// R5: Countdown flag set on event, held
// R6: Countdown drives pin only when enabled
// R7: Countdown pulse auto releases, retriggers next event
// R8: Disabling countdown stops it, releases pin
// R9: Dropping countdown enable releases pin immediately
// R10: Update event per second or minute
// R11: Update pulse 500 ms or 15.625 ms
// R12: Update flag set on event; ones ignored
// R13: Clearing update flag releases pin
// R14: Update drives pin only when enabled
// R15: Dropping update enable releases pin immediately
// R16: Reset bit suppresses update events
// R17: Fixed-zero bits ignore writes, read zero
// R18: Shared pin: any active source drives
// R19: Host disables update interrupt before reconfiguring
// R20: Clock select picks countdown source
// R21: Countdown pulse 122 us or 7.813 ms
// R22: Clearing countdown flag keeps pin low
// R23: Preset in three bytes, count readable
// R24: Open-drain active-low interrupt output
`timescale 1ns/1ps
`default_nettype none
module rtcw_core
	import rtcw_pkg::*;
#(
	parameter int CD_FAST_CYC = CD_FAST_PULSE_CYC,
	parameter int CD_SLOW_CYC = CD_SLOW_PULSE_CYC,
	parameter int UP_SEC_CYC = UP_SEC_PULSE_CYC,
	parameter int UP_MIN_CYC = UP_MIN_PULSE_CYC
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic SCL_IN,
	input wire rtcw_wr_t REG_WR,
	input wire logic [7:0] REG_RADDR,
	output logic [7:0] REG_RDATA,
	input wire rtcw_ticks_t TICKS,
	output logic IRQ_N_OUT,
	output logic IRQ_N_OE_N
);
	generate
		if (CD_FAST_CYC < 1 || CD_SLOW_CYC < 1 || UP_SEC_CYC < 1 || UP_MIN_CYC < 1) begin : g_chk1
			$error("pulse lengths must be at least one cycle");
		end
		if (CD_SLOW_CYC >= 2**PULSE_W || UP_SEC_CYC >= 2**PULSE_W) begin : g_chk2
			$error("pulse lengths exceed the pulse counter width");
		end
		if (CD_FAST_CYC >= 2**PULSE_W || UP_MIN_CYC >= 2**PULSE_W) begin : g_chk3
			$error("pulse lengths exceed the pulse counter width");
		end
	endgenerate

	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [PRESET_W-1:0] preset_q;
	logic [PRESET_W-1:0] cnt_q;
	logic tf_q;
	logic uf_q;
	logic scl_lvl;
	logic scl_prev_q;
	logic scl_rise;
	rtcw_cd_state_t cd_state_q;
	logic te;
	logic countdown_irq_enable;
	logic update_irq_enable;
	logic update_period_select;
	logic rst_bit;
	rtcw_src_t tsel;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic wr_flags;
	logic te_rise_wr;
	logic te_off_wr;
	logic src_tick;
	logic cd_event;
	logic up_event;
	logic cd_active;
	logic up_active;
	logic cd_drive;
	logic up_drive;
	logic [PULSE_W-1:0] cd_len;
	logic [PULSE_W-1:0] up_len;

	assign te = ctrl1_q[CTRL1_TE];
	assign update_period_select = ctrl1_q[CTRL1_UPDATE_PERIOD_SELECT];
	assign tsel = rtcw_src_t'(ctrl1_q[CTRL1_TSEL_LO +: 2]);
	assign countdown_irq_enable = ctrl2_q[CTRL2_TIE];
	assign update_irq_enable = ctrl2_q[CTRL2_UIE];
	assign rst_bit = ctrl2_q[CTRL2_RESET];

	assign wr_ctrl1 = REG_WR.en && (REG_WR.addr == ADDR_CTRL1);
	assign wr_ctrl2 = REG_WR.en && (REG_WR.addr == ADDR_CTRL2);
	assign wr_flags = REG_WR.en && (REG_WR.addr == ADDR_FLAGS);
	assign te_rise_wr = wr_ctrl1 && REG_WR.data[CTRL1_TE] && !te;
	assign te_off_wr = wr_ctrl1 && !REG_WR.data[CTRL1_TE];

	// Serial clock edge finder
	rtcw_sync3 u_scl_sync (
		.clk(MCLK),
		.rst_n(RST_N),
		.async_in(SCL_IN),
		.level_q(scl_lvl)
	);

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			scl_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_lvl;
		end
	end

	assign scl_rise = scl_lvl && !scl_prev_q;

	// Control registers
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			ctrl1_q <= CTRL1_RST;
			ctrl2_q <= CTRL2_RST;
		end else begin
			// R17: fixed bits masked
			if (wr_ctrl1) begin
				ctrl1_q <= REG_WR.data & CTRL1_MASK;
			end
			if (wr_ctrl2) begin
				ctrl2_q <= REG_WR.data & CTRL2_MASK;
			end
		end
	end

	// R23: preset bytes
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			preset_q <= PRESET_RST;
		end else if (REG_WR.en) begin
			if (REG_WR.addr == ADDR_PRESET0) begin
				preset_q[7:0] <= REG_WR.data;
			end
			if (REG_WR.addr == ADDR_PRESET1) begin
				preset_q[15:8] <= REG_WR.data;
			end
			if (REG_WR.addr == ADDR_PRESET2) begin
				preset_q[23:16] <= REG_WR.data;
			end
		end
	end

	// R20: source clock select
	always_comb begin
		unique case (tsel)
			SRC_4096HZ: src_tick = TICKS.hz4096;
			SRC_64HZ: src_tick = TICKS.hz64;
			SRC_1HZ: src_tick = TICKS.hz1;
			SRC_MINUTE: src_tick = TICKS.min_upd;
		endcase
	end

	// Countdown sequencer
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			cd_state_q <= CD_IDLE;
		end else if (te_off_wr) begin
			// R8: stop on disable
			cd_state_q <= CD_IDLE;
		end else begin
			unique case (cd_state_q)
				CD_IDLE: begin
					if (te_rise_wr) begin
						cd_state_q <= CD_ARMED;
					end
				end
				CD_ARMED: begin
					// R1: align to serial clock
					if (scl_rise) begin
						cd_state_q <= CD_LOAD;
					end
				end
				CD_LOAD: begin
					// R2: first tick loads
					if (src_tick) begin
						cd_state_q <= CD_RUN;
					end
				end
				CD_RUN: begin
					cd_state_q <= CD_RUN;
				end
			endcase
		end
	end

	// R3: count, reload on reaching zero
	// R4: preset zero gives no event
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			cnt_q <= PRESET_RST;
		end else if (cd_state_q == CD_IDLE || te_off_wr) begin
			cnt_q <= preset_q;
		end else if (src_tick && cd_state_q == CD_LOAD) begin
			cnt_q <= preset_q;
		end else if (src_tick && cd_state_q == CD_RUN) begin
			if (cnt_q == 24'h000001) begin
				cnt_q <= preset_q;
			end else if (cnt_q != 24'h000000) begin
				cnt_q <= cnt_q - 24'h000001;
			end
		end
	end

	assign cd_event = src_tick && (cd_state_q == CD_RUN) && (cnt_q == 24'h000001) && !te_off_wr;

	// R10: update source select
	// R16: reset bit suppresses
	assign up_event = !rst_bit && (update_period_select ? TICKS.min_upd : TICKS.sec_upd);

	// R5: countdown flag, set wins over clear
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			tf_q <= 1'b0;
		end else if (cd_event) begin
			tf_q <= 1'b1;
		end else if (wr_flags && !REG_WR.data[FLAGS_TF]) begin
			tf_q <= 1'b0;
		end
	end

	// R12: update flag, writing one ignored
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			uf_q <= 1'b0;
		end else if (up_event) begin
			uf_q <= 1'b1;
		end else if (wr_flags && !REG_WR.data[FLAGS_UF]) begin
			uf_q <= 1'b0;
		end
	end

	// R21: countdown pulse length
	assign cd_len = (tsel == SRC_4096HZ) ? PULSE_W'(CD_FAST_CYC) : PULSE_W'(CD_SLOW_CYC);
	// R11: update pulse length
	assign up_len = update_period_select ? PULSE_W'(UP_MIN_CYC) : PULSE_W'(UP_SEC_CYC);

	// R7: countdown pulse, retriggered per event
	// R9: enable drop kills pulse
	// R22: flag clear leaves pulse
	rtcw_pulse #(
		.W(PULSE_W)
	) u_cd_pulse (
		.clk(MCLK),
		.rst_n(RST_N),
		.start(cd_event && countdown_irq_enable),
		.kill(te_off_wr || !countdown_irq_enable),
		.len(cd_len),
		.active(cd_active)
	);

	// R13: flag clear kills pulse
	// R14: only with enable
	// R15: enable drop kills pulse
	rtcw_pulse #(
		.W(PULSE_W)
	) u_up_pulse (
		.clk(MCLK),
		.rst_n(RST_N),
		.start(up_event && update_irq_enable),
		.kill((wr_flags && !REG_WR.data[FLAGS_UF] && !up_event) || !update_irq_enable),
		.len(up_len),
		.active(up_active)
	);

	// R6: gated by enable
	assign cd_drive = cd_active && countdown_irq_enable && te;
	assign up_drive = up_active && update_irq_enable;

	// R18: shared open-drain pin
	// R24: active low, released otherwise
	assign IRQ_N_OUT = 1'b0;
	assign IRQ_N_OE_N = !(cd_drive || up_drive);

	// R17: read mux, fixed zero bits
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else begin
			unique case (REG_RADDR)
				ADDR_CTRL1: REG_RDATA <= ctrl1_q;
				ADDR_CTRL2: REG_RDATA <= ctrl2_q;
				ADDR_FLAGS: REG_RDATA <= {2'b00, uf_q, tf_q, 4'h0};
				ADDR_PRESET0: REG_RDATA <= preset_q[7:0];
				ADDR_PRESET1: REG_RDATA <= preset_q[15:8];
				ADDR_PRESET2: REG_RDATA <= preset_q[23:16];
				ADDR_COUNT0: REG_RDATA <= cnt_q[7:0];
				ADDR_COUNT1: REG_RDATA <= cnt_q[15:8];
				ADDR_COUNT2: REG_RDATA <= cnt_q[23:16];
				default: REG_RDATA <= 8'h00;
			endcase
		end
	end

	sequence s_armed_edge;
		(cd_state_q == CD_ARMED) && scl_rise && !te_off_wr;
	endsequence

	sequence s_load_tick;
		(cd_state_q == CD_LOAD) && src_tick && !te_off_wr;
	endsequence

	property p_start_on_scl;
		@(posedge MCLK) disable iff (!RST_N)
		s_armed_edge |=> (cd_state_q == CD_LOAD);
	endproperty
	a_start_on_scl: assert property (p_start_on_scl) else $error("countdown did not start on clock rise"); // R1

	property p_first_load;
		@(posedge MCLK) disable iff (!RST_N)
		s_load_tick |=> (cd_state_q == CD_RUN) && (cnt_q == $past(preset_q));
	endproperty
	a_first_load: assert property (p_first_load) else $error("first tick did not load the preset"); // R2

	property p_wait_scl;
		@(posedge MCLK) disable iff (!RST_N)
		(cd_state_q == CD_ARMED) && !scl_rise |=> (cd_state_q != CD_LOAD) && (cd_state_q != CD_RUN);
	endproperty
	a_wait_scl: assert property (p_wait_scl) else $error("countdown began before serial clock rise"); // R1

	property p_decrement;
		@(posedge MCLK) disable iff (!RST_N)
		(cd_state_q == CD_RUN) && src_tick && (cnt_q > 24'h000001) && !te_off_wr
			|=> cnt_q == $past(cnt_q) - 24'h000001;
	endproperty
	a_decrement: assert property (p_decrement) else $error("count did not decrement by one"); // R3

	property p_reload;
		@(posedge MCLK) disable iff (!RST_N)
		cd_event |=> (cnt_q == $past(preset_q)) && tf_q;
	endproperty
	a_reload: assert property (p_reload) else $error("event did not reload and flag"); // R5

	property p_cd_drive;
		@(posedge MCLK) disable iff (!RST_N)
		cd_event && countdown_irq_enable |=> !IRQ_N_OE_N ##1 (!IRQ_N_OE_N || !(te && countdown_irq_enable)) [*2];
	endproperty
	a_cd_drive: assert property (p_cd_drive) else $error("countdown event did not pull pin low"); // R6

	property p_te_off;
		@(posedge MCLK) disable iff (!RST_N)
		te_off_wr && !up_drive && !up_event |=> IRQ_N_OE_N && (cd_state_q == CD_IDLE);
	endproperty
	a_te_off: assert property (p_te_off) else $error("disable did not stop and release"); // R8

	property p_tie_drop;
		@(posedge MCLK) disable iff (!RST_N)
		$fell(countdown_irq_enable) && !up_drive |-> IRQ_N_OE_N;
	endproperty
	a_tie_drop: assert property (p_tie_drop) else $error("countdown enable drop kept pin low"); // R9

	property p_uf_ones_ignored;
		@(posedge MCLK) disable iff (!RST_N)
		wr_flags && REG_WR.data[FLAGS_UF] && !uf_q && !up_event |=> !uf_q;
	endproperty
	a_uf_ones_ignored: assert property (p_uf_ones_ignored) else $error("writing one set update flag"); // R12

	property p_uf_clear_release;
		@(posedge MCLK) disable iff (!RST_N)
		wr_flags && !REG_WR.data[FLAGS_UF] && !up_event && !cd_drive && !cd_event |=> IRQ_N_OE_N;
	endproperty
	a_uf_clear_release: assert property (p_uf_clear_release) else $error("update flag clear kept pin low"); // R13

	property p_up_drive;
		@(posedge MCLK) disable iff (!RST_N)
		up_event && update_irq_enable |=> uf_q && !IRQ_N_OE_N;
	endproperty
	a_up_drive: assert property (p_up_drive) else $error("update event did not flag and drive"); // R14

	property p_reset_bit;
		@(posedge MCLK) disable iff (!RST_N)
		rst_bit && !uf_q && !(wr_flags) |=> !uf_q;
	endproperty
	a_reset_bit: assert property (p_reset_bit) else $error("update event while reset bit set"); // R16
endmodule
`default_nettype wire

// ### include/rtcw_pkg.sv
// Constants, field layout and carrier types of the wakeup/update interrupt block.
// Assumes a 250 MHz core clock and register access from a serial bus engine.
package rtcw_pkg;
	localparam real CLK_PERIOD_NS = 4.0;
	localparam int PRESET_W = 24;
	localparam int PULSE_W = 27;

	// Register addresses
	localparam logic [7:0] ADDR_PRESET0 = 8'h0B;
	localparam logic [7:0] ADDR_PRESET1 = 8'h0C;
	localparam logic [7:0] ADDR_COUNT0 = 8'h1C;
	localparam logic [7:0] ADDR_COUNT1 = 8'h1D;
	localparam logic [7:0] ADDR_COUNT2 = 8'h1E;
	localparam logic [7:0] ADDR_PRESET2 = 8'h1F;
	localparam logic [7:0] ADDR_CTRL1 = 8'h0D;
	localparam logic [7:0] ADDR_FLAGS = 8'h0E;
	localparam logic [7:0] ADDR_CTRL2 = 8'h0F;

	// Field positions
	localparam int CTRL1_UPDATE_PERIOD_SELECT = 5;
	localparam int CTRL1_TE = 4;
	localparam int CTRL1_TSEL_LO = 0;
	localparam int FLAGS_UF = 5;
	localparam int FLAGS_TF = 4;
	localparam int CTRL2_UIE = 5;
	localparam int CTRL2_TIE = 4;
	localparam int CTRL2_RESET = 0;

	// Writable masks, fixed-zero bits excluded
	localparam logic [7:0] CTRL1_MASK = 8'hFF;
	localparam logic [7:0] CTRL2_MASK = 8'hF9;

	// Reset values
	localparam logic [7:0] CTRL1_RST = 8'h02;
	localparam logic [7:0] CTRL2_RST = 8'h40;
	localparam logic [PRESET_W-1:0] PRESET_RST = 24'h000000;

	// Pulse times as printed
	localparam real CD_FAST_PULSE_US = 122.0;
	localparam real CD_SLOW_PULSE_MS = 7.813;
	localparam real UP_SEC_PULSE_MS = 500.0;
	localparam real UP_MIN_PULSE_MS = 15.625;
	localparam int CD_FAST_PULSE_CYC = int'($floor(CD_FAST_PULSE_US * 1000.0 / CLK_PERIOD_NS));
	localparam int CD_SLOW_PULSE_CYC = int'($floor(CD_SLOW_PULSE_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int UP_SEC_PULSE_CYC = int'($floor(UP_SEC_PULSE_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int UP_MIN_PULSE_CYC = int'($floor(UP_MIN_PULSE_MS * 1.0e6 / CLK_PERIOD_NS));

	typedef enum logic [1:0] {
		SRC_4096HZ = 2'b00,
		SRC_64HZ = 2'b01,
		SRC_1HZ = 2'b10,
		SRC_MINUTE = 2'b11
	} rtcw_src_t;

	typedef enum logic [1:0] {
		CD_IDLE = 2'b00,
		CD_ARMED = 2'b01,
		CD_LOAD = 2'b10,
		CD_RUN = 2'b11
	} rtcw_cd_state_t;

	// One register write from the bus engine
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} rtcw_wr_t;

	// Time base ticks from the oscillator and calendar
	typedef struct packed {
		logic hz4096;
		logic hz64;
		logic hz1;
		logic sec_upd;
		logic min_upd;
	} rtcw_ticks_t;
endpackage

// ### core/rtcw_sync3.sv
// Three-stage synchroniser with agreement filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rtcw_sync3 (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic level_q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level moves only when stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_q <= 1'b1;
		end else if (s2_q == s3_q) begin
			level_q <= s2_q;
		end
	end
endmodule
`default_nettype wire

// ### core/rtcw_pulse.sv
// Retriggerable pulse timer: holds active for a loaded number of cycles.
// Assumes start is a single-cycle strobe on clk; kill may be held high as a level.
`timescale 1ns/1ps
`default_nettype none
module rtcw_pulse #(
	parameter int W = 27
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic kill,
	input wire logic [W-1:0] len,
	output logic active
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (kill) begin
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= len;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign active = (cnt_q != '0);

	property p_pulse_starts;
		@(posedge clk) disable iff (!rst_n)
		start && !kill && (len != '0) |=> active && (cnt_q == $past(len));
	endproperty
	a_pulse_starts: assert property (p_pulse_starts) else $error("pulse did not load its length");
endmodule
`default_nettype wire

// ### bench/rtcw_host_model.sv
// Host side model: register writes wrapped in serial clock frames, reads.
// Assumes the bench calls its tasks; the serial clock idles high on its pull-up.
`timescale 1ns/1ps
`default_nettype none
module rtcw_host_model
	import rtcw_pkg::*;
(
	input wire logic clk,
	output var logic scl,
	output var rtcw_wr_t wr,
	output var logic [7:0] raddr,
	input wire logic [7:0] rdata
);
	initial begin
		scl = 1'b1;
		wr = '0;
		raddr = 8'h00;
	end

	// One bit time of 80 ns, clock only moves inside a frame
	task automatic scl_bit();
		@(posedge clk) scl <= 1'b0;
		repeat (10) @(posedge clk);
		scl <= 1'b1;
		repeat (10) @(posedge clk);
	endtask

	// Data byte clocks, write strobe, then the acknowledge clock rise
	task automatic write(input logic [7:0] a, input logic [7:0] d, input bit framed);
		if (framed) repeat (8) scl_bit();
		@(posedge clk) wr <= {1'b1, a, d};
		@(posedge clk) wr <= '0;
		if (framed) scl_bit();
	endtask

	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) raddr <= a;
		repeat (2) @(posedge clk);
		#1 d = rdata;
	endtask
endmodule
`default_nettype wire

// ### bench/test_wakeup_and_update_interrupts.sv
// Self-checking bench of the wakeup countdown and update interrupt block.
// Assumes the host model for register traffic; ticks come from the bench.
`timescale 1ns/1ps
`default_nettype none
module test_wakeup_and_update_interrupts
	import rtcw_pkg::*;
;
	localparam int CD_F = 8;
	localparam int CD_S = 20;
	localparam int UP_S = 60;
	localparam int UP_M = 30;
	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic scl;
	rtcw_wr_t bus_wr;
	logic [7:0] raddr;
	logic [7:0] rdata;
	rtcw_ticks_t ticks = '0;
	logic oe_n;
	logic irq_out;
	logic irq_n;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int p;
	int n;
	logic [4:0] m;
	logic [31:0] lfsr_q = 32'h00E1;

	// Open-drain pin with pull-up
	assign irq_n = oe_n ? 1'b1 : irq_out;

	rtcw_core #(.CD_FAST_CYC(CD_F), .CD_SLOW_CYC(CD_S), .UP_SEC_CYC(UP_S), .UP_MIN_CYC(UP_M)) u_dut (
		.MCLK(MCLK), .RST_N(RST_N), .SCL_IN(scl), .REG_WR(bus_wr), .REG_RADDR(raddr),
		.REG_RDATA(rdata), .TICKS(ticks), .IRQ_N_OUT(irq_out), .IRQ_N_OE_N(oe_n));

	rtcw_host_model u_host (.clk(MCLK), .scl(scl), .wr(bus_wr), .raddr(raddr), .rdata(rdata));

	always #2 MCLK = ~MCLK;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic summarize();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_host.read(a, d);
		check(d, exp);
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		u_host.write(a, d, 1'b1);
	endtask

	// Bare strobe, frame assumed done; lets a write land inside a pulse
	task automatic wfast(input logic [7:0] a, input logic [7:0] d);
		u_host.write(a, d, 1'b0);
		#1;
	endtask

	task automatic tick(input logic [4:0] t);
		@(posedge MCLK) ticks <= rtcw_ticks_t'(t);
		@(posedge MCLK) ticks <= '0;
		#1;
	endtask

	task automatic plen(output int k);
		k = 0;
		while (oe_n === 1'b0 && k < 2000) begin
			@(posedge MCLK);
			#1;
			k++;
		end
	endtask

	// Counts down from the preset; a foreign tick in between must not count
	task automatic cd_event();
		repeat (p - 1) begin
			tick(m);
			check(irq_n, 1'b1); // no early event
		end
		tick(~m & 5'b11101);
		check(irq_n, 1'b1); // other source ignored
		tick(m);
		check(irq_n, 1'b0); // event drives pin
	endtask

	initial begin
		repeat (5) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		#1;
		rchk(ADDR_CTRL1, 8'h02); // default per second
		rchk(ADDR_CTRL2, 8'h40); // reset value
		rchk(ADDR_FLAGS, 8'h00); // flags clear
		rchk(8'h10, 8'h00); // unmapped reads zero
		check(irq_n, 1'b1); // pin released
		lfsr_q = lfsr_next(lfsr_q);
		wreg(ADDR_CTRL2, lfsr_q[7:0]);
		rchk(ADDR_CTRL2, lfsr_q[7:0] & 8'hF9); // fixed zero bits
		wreg(ADDR_FLAGS, 8'hFF);
		rchk(ADDR_FLAGS, 8'h00); // ones ignored
		for (int s = 0; s < 4; s++) begin
			lfsr_q = lfsr_next(lfsr_q);
			p = int'(lfsr_q[1:0]) + 1;
			m = (s == 3) ? 5'b00001 : (5'b10000 >> s);
			wreg(ADDR_PRESET0, 8'(p));
			wreg(ADDR_PRESET1, 8'h00);
			wreg(ADDR_PRESET2, 8'h00);
			wreg(ADDR_CTRL2, {lfsr_q[9:8], 6'h10});
			wreg(ADDR_FLAGS, 8'h00);
			wreg(ADDR_CTRL1, {6'b000100, 2'(s)});
			tick(m);
			rchk(ADDR_COUNT0, 8'(p)); // preset loaded
			rchk(ADDR_PRESET0, 8'(p)); // preset kept
			cd_event();
			plen(n);
			check(n, (s == 0) ? CD_F : CD_S); // pulse time
			rchk(ADDR_FLAGS, 8'h10); // flag held
			cd_event();
			wfast(ADDR_FLAGS, 8'h00);
			check(irq_n, 1'b0); // flag clear keeps pin
			wfast(ADDR_CTRL2, 8'h40);
			check(irq_n, 1'b1); // enable drop releases
			wfast(ADDR_CTRL2, 8'h50);
			cd_event();
			wfast(ADDR_CTRL1, {6'b000000, 2'(s)});
			check(irq_n, 1'b1); // stop releases pin
			repeat (p + 1) tick(m);
			check(irq_n, 1'b1); // countdown stopped
		end
		wreg(ADDR_CTRL2, 8'h40);
		wreg(ADDR_CTRL1, 8'h02);
		wreg(ADDR_FLAGS, 8'h00);
		wreg(ADDR_CTRL2, 8'h60);
		tick(5'b00010);
		check(irq_n, 1'b0); // pin low on event
		plen(n);
		check(n, UP_S); // per second pulse
		rchk(ADDR_FLAGS, 8'h20); // flag set
		tick(5'b00010);
		wfast(ADDR_FLAGS, 8'h00);
		check(irq_n, 1'b1); // flag clear releases
		tick(5'b00010);
		wfast(ADDR_CTRL2, 8'h40);
		check(irq_n, 1'b1); // enable drop releases
		wreg(ADDR_FLAGS, 8'h00);
		tick(5'b00010);
		check(irq_n, 1'b1); // disabled pin idle
		rchk(ADDR_FLAGS, 8'h20); // flag set while disabled
		wreg(ADDR_CTRL2, 8'h41);
		wreg(ADDR_FLAGS, 8'h00);
		tick(5'b00010);
		rchk(ADDR_FLAGS, 8'h00); // reset bit blocks
		wreg(ADDR_CTRL2, 8'h40);
		wreg(ADDR_CTRL1, 8'h23);
		wreg(ADDR_CTRL2, 8'h60);
		tick(5'b00010);
		check(irq_n, 1'b1); // seconds ignored
		tick(5'b00001);
		check(irq_n, 1'b0); // minute event
		plen(n);
		check(n, UP_M); // per minute pulse
		wreg(ADDR_PRESET0, 8'h01);
		wreg(ADDR_CTRL2, 8'h70);
		wreg(ADDR_CTRL1, 8'h33);
		tick(5'b00001);
		tick(5'b00001);
		check(irq_n, 1'b0); // both sources low
		wfast(ADDR_CTRL2, 8'h60);
		check(irq_n, 1'b0); // other source holds
		wfast(ADDR_CTRL2, 8'h40);
		check(irq_n, 1'b1); // released when none
		summarize();
	end
endmodule
`default_nettype wire
